// >>> inc/sfmc_pkg.sv
// constants, field layout and carrier types of the forwarding mode control block
// ============================================================================
// How it works
// - bit 0 set means each packet is fully buffered before it is forwarded; clear (reset) means cut-through.
// - the two-bit threshold in bits 2:1 governs slow-to-fast forwarding and resets to one cycle early.
// - code 00b starts at the packet midpoint, codes 01b, 10b, 11b start one, two, three cycles earlier.
// - bit 3 set keeps the arbiter on the granted port while it requests and done_i is low, even without enough credit.
// - bit 3 clear (reset) moves the arbiter to a requesting port whose packet has enough credit.
// - bit 4 set releases new flow-control credit to the link partner one credit per update.
// - bit 4 clear (reset) releases new flow-control credit two credits per update.
// - bit 5 set enforces ordering between packets for different egress ports; reset clear.
// - bit 6 set keeps ordering between completions with different tags; resets set.
// - bit 7 set store-forwards non-posted packets, clear cuts them through; resets set.
// - a write to bit 7 stores the inverse of the written value.
// - the mode register lives only in the upstream port's space at 850h and acts switch-wide.
package sfmc_pkg;

    // ========================================================================
    // register map
    localparam logic [11:0] FWD_MODE_OFS = 12'h850;
    localparam logic [11:0] LINK_TRAIN_OFS = 12'h854;

    // ========================================================================
    // forwarding mode fields
    localparam int FWD_SF_BIT = 0;
    localparam int FWD_THR_LSB = 1;
    localparam int FWD_ARB_BIT = 3;
    localparam int FWD_CREDIT_BIT = 4;
    localparam int FWD_ORD_EGR_BIT = 5;
    localparam int FWD_ORD_TAG_BIT = 6;
    localparam int FWD_NP_SF_BIT = 7;
    localparam logic [7:0] FWD_MODE_RST = 8'hC2;
    localparam logic [7:0] FWD_MODE_INV = 8'h80;

    // ========================================================================
    // link training control fields
    localparam logic [15:0] LINK_TRAIN_RST = 16'h0080;
    localparam logic [15:0] LINK_TRAIN_WMASK = 16'h7FFF;

    // ========================================================================
    // forwarding timing
    localparam int PKT_LEN_W = 10;
    localparam logic [1:0] CREDIT_STEP_ONE = 2'h1;
    localparam logic [1:0] CREDIT_STEP_TWO = 2'h2;

    // ========================================================================
    // carriers
    typedef struct packed {
        logic valid;
        logic write;
        logic upstream;
        logic [11:0] addr;
        logic [3:0] byte_en;
        logic [31:0] wdata;
    } sfmc_cfg_req_t;

    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
    } sfmc_cfg_rsp_t;

    typedef struct packed {
        logic start;
        logic nonposted;
        logic slow_to_fast;
        logic [PKT_LEN_W-1:0] len;
    } sfmc_pkt_t;

    typedef enum logic [1:0] {
        FWD_IDLE = 2'b00,
        FWD_RECV = 2'b01,
        FWD_SENT = 2'b11
    } sfmc_fwd_state_t;

endpackage

// >>> hdl/sfmc_rr_arbiter.sv
// round-robin port arbiter with hold or credit-skip behaviour
`timescale 1ns/10ps
module sfmc_rr_arbiter #(
    parameter int PORTS = 4
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    // mode
    input wire logic hold_mode_i,
    // ports
    input wire logic [PORTS-1:0] req_i,
    input wire logic [PORTS-1:0] credit_ok_i,
    input wire logic done_i,
    // grant
    output logic [PORTS-1:0] grant_o
);
    import sfmc_pkg::*;

    // first eligible port after the current one, in round-robin order
    function automatic logic [PORTS-1:0] rr_pick(input logic [PORTS-1:0] elig,
                                                 input logic [PORTS-1:0] cur);
        logic [PORTS-1:0] pick;
        logic [2*PORTS-1:0] ring;
        int start;
        pick = '0;
        ring = {elig, elig};
        start = 0;
        for (int i = 0; i < PORTS; i++)
        begin
            if (cur[i])
                start = i + 1;
        end
        for (int k = PORTS - 1; k >= 0; k--)
        begin
            if (ring[start + k])
                pick = '0;
            if (ring[start + k])
                pick[(start + k) % PORTS] = 1'b1;
        end
        return pick;
    endfunction

    logic cur_req;
    logic cur_credit;
    assign cur_req = |(grant_o & req_i);
    assign cur_credit = |(grant_o & credit_ok_i);

    always_ff @(posedge ref_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            grant_o <= '0;
        else if (hold_mode_i && cur_req && !done_i)
            grant_o <= grant_o;
        else if (!hold_mode_i && cur_req && cur_credit && !done_i)
            grant_o <= grant_o;
        else if (hold_mode_i)
            grant_o <= rr_pick(req_i, grant_o);
        else
            grant_o <= rr_pick(req_i & credit_ok_i, grant_o);
    end

endmodule

// >>> hdl/sfmc_credit_pacer.sv
// paces flow-control credit release to the link partner
`timescale 1ns/10ps
module sfmc_credit_pacer #(
    parameter int CNT_W = 8
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    // mode and source
    input wire logic one_per_update_i,
    input wire logic credit_new_i,
    // release
    output logic rel_valid_o,
    output logic [1:0] rel_count_o
);
    import sfmc_pkg::*;

    logic [CNT_W-1:0] pending;
    logic [1:0] step;
    logic fire;
    assign step = one_per_update_i ? CREDIT_STEP_ONE : CREDIT_STEP_TWO;
    // a lone credit in two-per mode waits for its partner; that is the trade for fewer updates
    assign fire = pending >= CNT_W'(step);

    always_ff @(posedge ref_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            pending <= '0;
        else
            pending <= pending + CNT_W'(credit_new_i) - (fire ? CNT_W'(step) : '0);
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            rel_valid_o <= 1'b0;
            rel_count_o <= 2'h0;
        end
        else
        begin
            rel_valid_o <= fire;
            rel_count_o <= fire ? step : 2'h0;
        end
    end

endmodule

// >>> hdl/sfmc_forwarding_ctrl.sv
// forwarding mode register bank and the forwarding decisions it steers
`timescale 1ns/10ps
module sfmc_forwarding_ctrl #(
    parameter int PORTS = 4,
    parameter int CREDIT_W = 8
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    // configuration space access
    input wire sfmc_pkg::sfmc_cfg_req_t cfg_req_i,
    output sfmc_pkg::sfmc_cfg_rsp_t cfg_rsp_o,
    // serial eeprom preload and i2c writes
    input wire sfmc_pkg::sfmc_cfg_req_t side_req_i,
    // packet ingress
    input wire sfmc_pkg::sfmc_pkt_t pkt_i,
    input wire logic rx_beat_i,
    output logic fwd_go_o,
    output logic fwd_store_o,
    // arbitration
    input wire logic [PORTS-1:0] arb_req_i,
    input wire logic [PORTS-1:0] arb_credit_ok_i,
    input wire logic arb_done_i,
    output logic [PORTS-1:0] arb_grant_o,
    // credit release
    input wire logic credit_new_i,
    output logic credit_rel_valid_o,
    output logic [1:0] credit_rel_count_o,
    // ordering and link controls
    output logic order_cross_egress_o,
    output logic order_cpl_tag_o,
    output logic [15:0] link_training_control_o
);
    import sfmc_pkg::*;

    // ========================================================================
    // register write path
    logic [7:0] switch_forwarding_mode;
    logic [15:0] link_training_control;

    // merge one access into the forwarding mode value
    function automatic logic [7:0] fwd_write(input logic [7:0] cur, input sfmc_cfg_req_t r);
        logic [7:0] val;
        val = cur;
        if (r.byte_en[0])
            val = r.wdata[7:0] ^ FWD_MODE_INV;
        return val;
    endfunction

    // merge one access into the link training value
    function automatic logic [15:0] link_write(input logic [15:0] cur, input sfmc_cfg_req_t r);
        logic [15:0] val;
        val = cur;
        if (r.byte_en[0])
            val[7:0] = r.wdata[7:0];
        if (r.byte_en[1])
            val[15:8] = r.wdata[15:8];
        return val & LINK_TRAIN_WMASK;
    endfunction

    logic cfg_wr;
    logic side_wr;
    assign cfg_wr = cfg_req_i.valid && cfg_req_i.write && cfg_req_i.upstream;
    assign side_wr = side_req_i.valid && side_req_i.write;

    always_ff @(posedge ref_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            switch_forwarding_mode <= FWD_MODE_RST;
        else if (cfg_wr && cfg_req_i.addr == FWD_MODE_OFS)
            switch_forwarding_mode <= fwd_write(switch_forwarding_mode, cfg_req_i);
        else if (side_wr && side_req_i.addr == FWD_MODE_OFS)
            switch_forwarding_mode <= fwd_write(switch_forwarding_mode, side_req_i);
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            link_training_control <= LINK_TRAIN_RST;
        else if (cfg_wr && cfg_req_i.addr == LINK_TRAIN_OFS)
            link_training_control <= link_write(link_training_control, cfg_req_i);
        else if (side_wr && side_req_i.addr == LINK_TRAIN_OFS)
            link_training_control <= link_write(link_training_control, side_req_i);
    end

    // ========================================================================
    // register read path
    // downstream ports see nothing here: the bank exists once, for the whole switch
    logic [31:0] next_rdata;
    always_comb
    begin
        next_rdata = 32'h0000_0000;
        if (cfg_req_i.upstream && !cfg_req_i.write)
        begin
            if (cfg_req_i.addr == FWD_MODE_OFS)
                next_rdata = {24'h00_0000, switch_forwarding_mode};
            else if (cfg_req_i.addr == LINK_TRAIN_OFS)
                next_rdata = {16'h0000, link_training_control};
        end
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            cfg_rsp_o.ack <= 1'b0;
            cfg_rsp_o.rdata <= 32'h0000_0000;
        end
        else
        begin
            cfg_rsp_o.ack <= cfg_req_i.valid;
            cfg_rsp_o.rdata <= next_rdata;
        end
    end

    // ========================================================================
    // mode decode
    logic sf_all;
    logic sf_np;
    logic [1:0] thr_code;
    assign sf_all = switch_forwarding_mode[FWD_SF_BIT];
    assign sf_np = switch_forwarding_mode[FWD_NP_SF_BIT];
    assign thr_code = switch_forwarding_mode[FWD_THR_LSB +: 2];

    // beat at which forwarding of a packet may begin
    function automatic logic [PKT_LEN_W-1:0] start_beat(input sfmc_pkt_t p,
                                                        input logic store,
                                                        input logic [1:0] code);
        logic [PKT_LEN_W-1:0] mid;
        logic [PKT_LEN_W-1:0] thr;
        mid = p.len >> 1;
        thr = {{(PKT_LEN_W-1){1'b0}}, 1'b1};
        if (store)
            thr = p.len;
        else if (p.slow_to_fast && mid > PKT_LEN_W'(code))
            thr = mid - PKT_LEN_W'(code);
        if (thr == '0)
            thr = {{(PKT_LEN_W-1){1'b0}}, 1'b1};
        return thr;
    endfunction

    // ========================================================================
    // forwarding start sequencer
    sfmc_fwd_state_t fwd_state;
    logic [PKT_LEN_W-1:0] beats;
    logic [PKT_LEN_W-1:0] thr;
    logic pkt_store;
    logic [PKT_LEN_W-1:0] next_beats;
    assign pkt_store = sf_all || (pkt_i.nonposted && sf_np);
    assign next_beats = beats + PKT_LEN_W'(rx_beat_i);

    always_ff @(posedge ref_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            fwd_state <= FWD_IDLE;
            beats <= '0;
            thr <= '0;
            fwd_store_o <= 1'b0;
        end
        else
        begin
            case (fwd_state)
                FWD_IDLE:
                begin
                    if (pkt_i.start)
                    begin
                        fwd_state <= FWD_RECV;
                        beats <= PKT_LEN_W'(rx_beat_i);
                        thr <= start_beat(pkt_i, pkt_store, thr_code);
                        fwd_store_o <= pkt_store;
                    end
                end
                FWD_RECV:
                begin
                    beats <= next_beats;
                    if (next_beats >= thr)
                        fwd_state <= FWD_SENT;
                end
                FWD_SENT:
                begin
                    beats <= next_beats;
                    if (next_beats >= pkt_i.len || pkt_i.start)
                        fwd_state <= FWD_IDLE;
                end
                default:
                    fwd_state <= FWD_IDLE;
            endcase
        end
    end

    // one pulse per packet at the start point
    always_ff @(posedge ref_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            fwd_go_o <= 1'b0;
        else
            fwd_go_o <= (fwd_state == FWD_RECV) && (next_beats >= thr);
    end

    // ========================================================================
    // ordering and link controls
    always_ff @(posedge ref_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            order_cross_egress_o <= 1'b0;
            order_cpl_tag_o <= 1'b1;
            link_training_control_o <= LINK_TRAIN_RST;
        end
        else
        begin
            order_cross_egress_o <= switch_forwarding_mode[FWD_ORD_EGR_BIT];
            order_cpl_tag_o <= switch_forwarding_mode[FWD_ORD_TAG_BIT];
            link_training_control_o <= link_training_control;
        end
    end

    // ========================================================================
    // arbiter and credit pacer
    sfmc_rr_arbiter #(
        .PORTS(PORTS)
    ) u_arb (
        .ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i),
        .hold_mode_i(switch_forwarding_mode[FWD_ARB_BIT]),
        .req_i(arb_req_i),
        .credit_ok_i(arb_credit_ok_i),
        .done_i(arb_done_i),
        .grant_o(arb_grant_o)
    );

    sfmc_credit_pacer #(
        .CNT_W(CREDIT_W)
    ) u_credit (
        .ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i),
        .one_per_update_i(switch_forwarding_mode[FWD_CREDIT_BIT]),
        .credit_new_i(credit_new_i),
        .rel_valid_o(credit_rel_valid_o),
        .rel_count_o(credit_rel_count_o)
    );

endmodule

// >>> testbench/sfmc_fwd_assertions.sv
// assertion checker for the forwarding mode control block
`timescale 1ns/10ps
module sfmc_fwd_assertions #(
    parameter int PORTS = 4,
    parameter int CREDIT_W = 8
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    // configuration
    input wire sfmc_pkg::sfmc_cfg_req_t cfg_req_i,
    input wire sfmc_pkg::sfmc_cfg_rsp_t cfg_rsp_o,
    input wire sfmc_pkg::sfmc_cfg_req_t side_req_i,
    // packets
    input wire sfmc_pkg::sfmc_pkt_t pkt_i,
    input wire logic rx_beat_i,
    input wire logic fwd_go_o,
    input wire logic fwd_store_o,
    // arbitration
    input wire logic [PORTS-1:0] arb_req_i,
    input wire logic [PORTS-1:0] arb_credit_ok_i,
    input wire logic arb_done_i,
    input wire logic [PORTS-1:0] arb_grant_o,
    // credit and controls
    input wire logic credit_new_i,
    input wire logic credit_rel_valid_o,
    input wire logic [1:0] credit_rel_count_o,
    input wire logic order_cross_egress_o,
    input wire logic order_cpl_tag_o,
    input wire logic [15:0] link_training_control_o
);
    import sfmc_pkg::*;
    // ====
    // helpers
    logic rd;
    logic wr_mode;
    logic quiet;
    assign rd = cfg_req_i.valid && !cfg_req_i.write;
    assign wr_mode = cfg_req_i.valid && cfg_req_i.write && cfg_req_i.upstream
        && cfg_req_i.addr == FWD_MODE_OFS && cfg_req_i.byte_en[0] && !side_req_i.valid;
    // a following write would hide the level under test
    assign quiet = !(cfg_req_i.valid && cfg_req_i.write) && !side_req_i.valid;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);
    // ====
    // properties
    AST_ACK_ONCE: assert property (cfg_rsp_o.ack == $past(cfg_req_i.valid))
        else $error("ack does not follow request");
    AST_FOREIGN_RD: assert property (rd && !cfg_req_i.upstream |=> cfg_rsp_o.rdata == 32'h0)
        else $error("downstream read not zero");
    AST_UNMAPPED_RD: assert property (rd && cfg_req_i.addr != FWD_MODE_OFS
        && cfg_req_i.addr != LINK_TRAIN_OFS |=> cfg_rsp_o.rdata == 32'h0)
        else $error("unmapped read not zero");
    AST_MODE_RSVD: assert property (rd && cfg_req_i.addr == FWD_MODE_OFS
        |=> cfg_rsp_o.rdata[31:8] == 24'h0)
        else $error("mode reserved bits set");
    AST_LINK_RSVD: assert property (link_training_control_o[15] == 1'b0)
        else $error("link control bit 15 set");
    AST_EGR_ORDER: assert property (wr_mode ##1 quiet
        |=> order_cross_egress_o == $past(cfg_req_i.wdata[5], 2))
        else $error("egress ordering level wrong");
    AST_TAG_ORDER: assert property (wr_mode ##1 quiet
        |=> order_cpl_tag_o == $past(cfg_req_i.wdata[6], 2))
        else $error("tag ordering level wrong");
    AST_CREDIT_STEP: assert property (credit_rel_valid_o ? credit_rel_count_o inside {2'h1, 2'h2}
        : credit_rel_count_o == 2'h0)
        else $error("credit release count wrong");
    AST_GRANT_REQ: assert property (|arb_grant_o
        |-> $onehot(arb_grant_o) && |(arb_grant_o & $past(arb_req_i)))
        else $error("grant without request");
    AST_GO_PULSE: assert property (fwd_go_o |=> !fwd_go_o)
        else $error("forward start longer than a pulse");
endmodule

bind sfmc_forwarding_ctrl sfmc_fwd_assertions #(.PORTS(PORTS), .CREDIT_W(CREDIT_W))
    i_sfmc_fwd_assertions (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .cfg_req_i(cfg_req_i), .cfg_rsp_o(cfg_rsp_o), .side_req_i(side_req_i), .pkt_i(pkt_i),
    .rx_beat_i(rx_beat_i), .fwd_go_o(fwd_go_o), .fwd_store_o(fwd_store_o),
    .arb_req_i(arb_req_i), .arb_credit_ok_i(arb_credit_ok_i), .arb_done_i(arb_done_i),
    .arb_grant_o(arb_grant_o), .credit_new_i(credit_new_i),
    .credit_rel_valid_o(credit_rel_valid_o), .credit_rel_count_o(credit_rel_count_o),
    .order_cross_egress_o(order_cross_egress_o), .order_cpl_tag_o(order_cpl_tag_o),
    .link_training_control_o(link_training_control_o));

// >>> testbench/switch_forwarding_mode_control_tb.sv
// self-checking bench for the forwarding mode control block
`timescale 1ns/10ps
module switch_forwarding_mode_control_tb;
    import sfmc_pkg::*;
    logic ref_clk_i;
    logic sys_rst_i;
    sfmc_cfg_req_t cfg_req;
    sfmc_cfg_rsp_t cfg_rsp;
    sfmc_cfg_req_t side_req;
    sfmc_pkt_t pkt;
    logic rx_beat;
    logic fwd_go;
    logic fwd_store;
    logic [3:0] arb_req;
    logic [3:0] arb_ok;
    logic arb_done;
    logic [3:0] grant;
    logic credit_new;
    logic rel_valid;
    logic [1:0] rel_count;
    logic ord_egr;
    logic ord_tag;
    logic [15:0] link;
    int mismatches;
    int n_tests;
    logic [31:0] rd_q;

    sfmc_forwarding_ctrl #(.PORTS(4), .CREDIT_W(8)) i_dut (.ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i), .cfg_req_i(cfg_req), .cfg_rsp_o(cfg_rsp),
        .side_req_i(side_req), .pkt_i(pkt), .rx_beat_i(rx_beat), .fwd_go_o(fwd_go),
        .fwd_store_o(fwd_store), .arb_req_i(arb_req), .arb_credit_ok_i(arb_ok),
        .arb_done_i(arb_done), .arb_grant_o(grant), .credit_new_i(credit_new),
        .credit_rel_valid_o(rel_valid), .credit_rel_count_o(rel_count),
        .order_cross_egress_o(ord_egr), .order_cpl_tag_o(ord_tag),
        .link_training_control_o(link));

    // ====
    // helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            mismatches++;
            $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic wrap_up();
        if (mismatches == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // inputs always move 1 ns after the edge
    task automatic tick();
        @(posedge ref_clk_i);
        #1;
    endtask

    task automatic cfg(input logic w, input logic up, input logic [11:0] a,
                       input logic [3:0] be, input logic [31:0] d, output logic [31:0] q);
        cfg_req = '{1'b1, w, up, a, be, d};
        tick();
        cfg_req.valid = 1'b0;
        chk(cfg_rsp.ack, 1'b1);
        q = cfg_rsp.rdata;
        // one idle cycle so the next call never re-raises valid in this time step
        tick();
    endtask

    task automatic wr(input logic [11:0] a, input logic [3:0] be, input logic [31:0] d);
        logic [31:0] q;
        cfg(1'b1, 1'b1, a, be, d, q);
    endtask

    task automatic rd_chk(input logic up, input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] q;
        cfg(1'b0, up, a, 4'hF, 32'h0, q);
        chk(q, exp);
    endtask

    // bit 7 is written inverted, so this stores m as given
    task automatic set_mode(input logic [7:0] m);
        wr(FWD_MODE_OFS, 4'h1, {24'h0, m ^ FWD_MODE_INV});
    endtask

    task automatic run_pkt(input logic np, input logic s2f, input int len, input int thr,
                           input logic st);
        int seen;
        seen = 0;
        pkt = '{1'b1, np, s2f, PKT_LEN_W'(len)};
        rx_beat = 1'b1;
        for (int i = 1; i <= len + 4; i++)
        begin
            tick();
            if (i == 1)
                pkt.start = 1'b0;
            if (i == len)
                rx_beat = 1'b0;
            if (fwd_go === 1'b1 && seen == 0)
                seen = i;
        end
        chk(seen, thr);
        chk(fwd_store, st);
    endtask

    task automatic run_credit(input int n, input logic [1:0] step);
        int hits;
        logic [1:0] cnt;
        hits = 0;
        cnt = 2'h0;
        for (int i = 0; i < n + 4; i++)
        begin
            credit_new = (i < n);
            tick();
            if (rel_valid === 1'b1)
            begin
                hits++;
                cnt = rel_count;
            end
        end
        chk(hits, 1);
        chk(cnt, step);
    endtask

    // take credit away from the granted port and see whether the grant moves
    task automatic run_arb(input logic hold);
        logic [3:0] g;
        arb_req = 4'h3;
        arb_ok = 4'h3;
        repeat (2) tick();
        g = grant;
        arb_ok = 4'h3 & ~g;
        repeat (2) tick();
        chk(grant, hold ? g : 4'h3 & ~g);
        if (hold)
        begin
            arb_done = 1'b1;
            tick();
            arb_done = 1'b0;
            tick();
            chk(grant, 4'h3 & ~g);
        end
        arb_req = 4'h0;
        repeat (2) tick();
    endtask

    // ====
    // stimulus
    initial
    begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end

    initial
    begin
        mismatches = 0;
        n_tests = 0;
        sys_rst_i = 1'b1;
        cfg_req = '0;
        side_req = '0;
        pkt = '0;
        rx_beat = 1'b0;
        arb_req = 4'h0;
        arb_ok = 4'h0;
        arb_done = 1'b0;
        credit_new = 1'b0;
        repeat (2) @(posedge ref_clk_i);
        #1;
        sys_rst_i = 1'b0;
        chk({ord_tag, ord_egr}, 2'h2);
        chk(link, 16'h0080);
        rd_chk(1'b1, FWD_MODE_OFS, 32'hC2);
        rd_chk(1'b1, LINK_TRAIN_OFS, 32'h80);
        wr(FWD_MODE_OFS, 4'hF, 32'hFFFFFFFF);
        rd_chk(1'b1, FWD_MODE_OFS, 32'h7F);
        chk({ord_tag, ord_egr}, 2'h3);
        wr(FWD_MODE_OFS, 4'h1, 32'h0);
        rd_chk(1'b1, FWD_MODE_OFS, 32'h80);
        chk({ord_tag, ord_egr}, 2'h0);
        // downstream space must not reach the register
        wr(FWD_MODE_OFS, 4'h1, 32'h7F);
        // a leaked write of zero would store 80h, so it cannot hide behind the FFh
        cfg(1'b1, 1'b0, FWD_MODE_OFS, 4'h1, 32'h0, rd_q);
        rd_chk(1'b0, FWD_MODE_OFS, 32'h0);
        rd_chk(1'b1, FWD_MODE_OFS, 32'hFF);
        wr(12'h858, 4'hF, 32'hFFFFFFFF);
        rd_chk(1'b1, 12'h858, 32'h0);
        wr(LINK_TRAIN_OFS, 4'hF, 32'hFFFFFFFF);
        rd_chk(1'b1, LINK_TRAIN_OFS, 32'h7FFF);
        chk(link, 16'h7FFF);
        side_req = '{1'b1, 1'b1, 1'b0, FWD_MODE_OFS, 4'h1, 32'hFF};
        tick();
        side_req.valid = 1'b0;
        rd_chk(1'b1, FWD_MODE_OFS, 32'h7F);
        for (int c = 0; c < 4; c++)
        begin
            set_mode(8'(c << 1));
            run_pkt(1'b0, 1'b1, 16, 8 - c, 1'b0);
        end
        // threshold one is judged only once the start edge has passed, so go shows at beat 2
        run_pkt(1'b0, 1'b1, 4, 2, 1'b0);
        run_pkt(1'b0, 1'b0, 16, 2, 1'b0);
        set_mode(8'h01);
        run_pkt(1'b0, 1'b1, 16, 16, 1'b1);
        set_mode(8'h80);
        run_pkt(1'b1, 1'b1, 16, 16, 1'b1);
        run_pkt(1'b0, 1'b1, 16, 8, 1'b0);
        set_mode(8'h00);
        run_credit(2, 2'h2);
        set_mode(8'h10);
        run_credit(1, 2'h1);
        set_mode(8'h00);
        run_arb(1'b0);
        set_mode(8'h08);
        run_arb(1'b1);
        wrap_up();
    end
endmodule
